// file: logic/opsup_pkg.sv
// constants, register map and types for the output protection supervisor
`default_nettype none
package opsup_pkg;
    localparam int CLK_PERIOD_NS     = 4;
    localparam int TICK_MS           = 100;
    localparam int TICK_NS           = 100_000_000;
    localparam int TICK_CYCLES       = TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_W            = 25;
    localparam int STARTUP_MS        = 500;
    localparam int STARTUP_TICKS     = STARTUP_MS / TICK_MS;
    localparam int BLINK_PERIOD_MS   = 2000;
    localparam int BLINK_HALF_TICKS  = BLINK_PERIOD_MS / 2 / TICK_MS;
    localparam int BLINK_W           = 5;
    localparam int START_W           = 4;
    localparam int CNT_W             = 9;
    localparam int V_W               = 16;
    localparam int DLY_W             = 8;

    // about 5 %: 51/1024
    localparam logic [5:0]  UV_MARGIN_MUL   = 6'h33;
    localparam int          UV_MARGIN_SHIFT = 10;

    localparam logic [7:0]  ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  ADDR_VSET    = 8'h04;
    localparam logic [7:0]  ADDR_FLOOR   = 8'h08;
    localparam logic [7:0]  ADDR_DELAY   = 8'h0C;
    localparam logic [7:0]  ADDR_STATUS  = 8'h10;

    localparam int CTRL_OUT_BIT   = 0;
    localparam int CTRL_AUTO_BIT  = 1;
    localparam int CTRL_UVEN_BIT  = 2;
    localparam int CTRL_FOLD_LSB  = 4;
    localparam int DLY_UV_LSB     = 0;
    localparam int DLY_FOLD_LSB   = 8;
    localparam int ST_ON_BIT      = 0;
    localparam int ST_FAULT_LSB   = 4;
    localparam int ST_UVTRIP_BIT  = 8;
    localparam int ST_FDL_BIT     = 9;
    localparam int ST_OT_BIT      = 10;
    localparam int ST_PF_BIT      = 11;
    localparam int ST_MODE_LSB    = 12;
    localparam int ST_START_BIT   = 14;

    localparam logic [V_W-1:0]   VSET_RST  = 16'h0000;
    localparam logic [V_W-1:0]   FLOOR_RST = 16'h0000;
    localparam logic [DLY_W-1:0] DLY_RST   = 8'h0A;
    localparam logic [DLY_W-1:0] DLY_ZERO  = 8'h00;

    typedef enum logic [2:0] {
        FLT_NONE = 3'b000,
        FLT_UV   = 3'b001,
        FLT_FOLD = 3'b011,
        FLT_OT   = 3'b010,
        FLT_PF   = 3'b110
    } opsup_fault_e;

    typedef enum logic [1:0] {
        FOLD_OFF  = 2'b00,
        FOLD_VOLT = 2'b01,
        FOLD_CURR = 2'b11
    } opsup_fold_e;

    typedef enum logic [1:0] {
        RMODE_NONE = 2'b00,
        RMODE_V    = 2'b01,
        RMODE_C    = 2'b11,
        RMODE_P    = 2'b10
    } opsup_rmode_e;
endpackage : opsup_pkg
`default_nettype wire

// file: logic/opsup_top.sv
// output protection supervisor with an AHB-Lite register slave
// Operation
// - undervolt_floor clamped to about 5% below voltage setting, floor zero; excess ignored.
// - undervolt_trip acts only when enabled; the floor clamps regardless.
// - enabled, output below floor for the delay: output shuts down.
// - floor, trip enable and fold mode writable with output on or off.
// - undervolt_trip delay programmable 0.1 s to 25.5 s.
// - undervolt delay runs from crossing the floor until shutdown.
// - undervolt trip disables output, shows its fault, blinks alarm at 1/2 Hz.
// - latched faults cleared by panel press, power cycle, analog cycle, comm enable.
// - fold trip has three states: off by default, voltage armed, current armed.
// - armed voltage trips into voltage_regulation; armed current into current_regulation.
// - fold indicators follow the armed state and vanish when set off.
// - fold trip delay programmable 0.1 s to 25.5 s.
// - fold delay runs from the regulation transition until shutdown.
// - fold trip disables output, shows fold fault, blinks alarm at 1/2 Hz.
// - after output off-to-on, 500 ms is added to both delays.
// - over-temperature shuts output down, shows fault, blinks alarm at 1/2 Hz.
// - after over-temperature, safe mode stays off; auto mode restores settings.
// - input_power_fault disables output, shows fault, blinks alarm at 1/2 Hz.
// - on power return, safe mode stays off; auto mode restores settings.
// - only the first active fault is shown; the next shows when it clears.
// - safe mode keeps settings but forces the output off.
//
// The AHB-Lite register port and the register offsets were decided locally.
`default_nettype none
module opsup_top #(
    parameter int P_TICK_CYCLES = opsup_pkg::TICK_CYCLES  // cycles per 0.1 s
) (
    input  wire logic        i_mclk,          // 250 MHz clock
    input  wire logic        i_rst,           // synchronous reset, high
    input  wire logic        i_hsel,          // ahb slave select
    input  wire logic [31:0] i_haddr,         // ahb address
    input  wire logic [1:0]  i_htrans,        // ahb transfer type
    input  wire logic        i_hwrite,        // ahb write
    input  wire logic [2:0]  i_hsize,         // ahb size, word only
    input  wire logic [31:0] i_hwdata,        // ahb write data
    input  wire logic        i_hready,        // ahb bus ready
    output logic [31:0]      o_hrdata,        // ahb read data
    output logic             o_hreadyout,     // ahb slave ready
    output logic             o_hresp,         // ahb response, okay
    input  wire logic [15:0] i_vout,          // measured output voltage
    input  wire logic        i_vreg,          // in voltage_regulation
    input  wire logic        i_creg,          // in current_regulation
    input  wire logic        i_preg,          // in power_regulation
    input  wire logic        i_overtemp,      // over-temperature detected
    input  wire logic        i_power_fault,   // input_power_fault present
    input  wire logic        i_panel_press,   // output button, one-cycle pulse
    input  wire logic        i_analog_en,     // analog interlock/enable level
    output logic             o_out_enable,    // power stage enable
    output logic [2:0]       o_fault_code,    // displayed fault
    output logic             o_alarm_led,     // red alarm, blinking
    output logic             o_fold_v_ind,    // voltage fold indicator
    output logic             o_fold_i_ind,    // current fold indicator
    output logic             o_out_off_ind    // output-off indication
);
    localparam int TW = opsup_pkg::TICK_W;
    localparam int CW = opsup_pkg::CNT_W;
    localparam int VW = opsup_pkg::V_W;
    localparam int DW = opsup_pkg::DLY_W;
    localparam logic [TW-1:0] TICK_LAST = TW'(P_TICK_CYCLES - 1);
    localparam logic [CW-1:0] CNT_MAX   = {CW{1'b1}};
    localparam logic [CW-1:0] START_ADD = CW'(opsup_pkg::STARTUP_TICKS);
    localparam logic [3:0]    START_END = 4'(opsup_pkg::STARTUP_TICKS);
    localparam logic [4:0]    BLK_HALF  = 5'(opsup_pkg::BLINK_HALF_TICKS);
    localparam logic [4:0]    BLK_LAST  = 5'(2 * opsup_pkg::BLINK_HALF_TICKS - 1);

    typedef struct packed {
        logic                     out_req;
        logic                     auto_mode;
        logic                     uv_en;
        opsup_pkg::opsup_fold_e   fold_mode;
        logic [VW-1:0]            vset;
        logic [VW-1:0]            floor;
        logic [DW-1:0]            uv_dly;
        logic [DW-1:0]            fold_dly;
        logic [TW-1:0]            presc;
        logic                     tick;
        logic [CW-1:0]            uv_cnt;
        logic [CW-1:0]            fold_cnt;
        logic                     startup;
        logic [3:0]               start_cnt;
        opsup_pkg::opsup_rmode_e  rmode;
        logic                     fold_pend;
        logic                     uv_latch;
        logic                     fold_latch;
        logic                     pf_q;
        logic                     en_q;
        opsup_pkg::opsup_fault_e  shown;
        logic [4:0]               blink;
        logic                     led;
        logic                     out_on;
        logic                     off_ind;
        logic                     fv_ind;
        logic                     fi_ind;
        logic                     wr_pend;
        logic [7:0]               wr_addr;
        logic [31:0]              rdata;
    } opsup_state_s;

    opsup_state_s s_q;
    opsup_state_s s_d;

    function automatic logic [VW-1:0] uv_max(input logic [VW-1:0] v);
        logic [VW+5:0] prod;
        prod = (VW+6)'(v) * (VW+6)'(opsup_pkg::UV_MARGIN_MUL);
        return v - VW'(prod >> opsup_pkg::UV_MARGIN_SHIFT);
    endfunction : uv_max

    function automatic logic [CW-1:0] thresh(input logic [DW-1:0] d, input logic st);
        return CW'(d) + (st ? START_ADD : CW'(0));
    endfunction : thresh

    logic                    addr_ok;
    logic [7:0]              a8;
    opsup_pkg::opsup_rmode_e new_mode;
    logic                    uv_cond;
    logic                    fold_evt;
    logic                    fold_hold;
    logic                    uv_trip;
    logic                    fold_trip;
    logic                    clr_evt;
    logic                    act_uv;
    logic                    act_fold;
    logic                    shown_act;
    logic [VW-1:0]           wv;

    always_comb begin
        s_d = s_q;
        a8 = i_haddr[7:0];
        addr_ok = i_hsel & i_htrans[1] & i_hready;
        wv = i_hwdata[VW-1:0];
        // free-running 0.1 s tick; delays carry up to one tick of jitter
        s_d.tick = (s_q.presc == TICK_LAST);
        s_d.presc = s_d.tick ? '0 : s_q.presc + TW'(1);

        // regulation mode from the feedback flags
        if (i_vreg) begin
            new_mode = opsup_pkg::RMODE_V;
        end else if (i_creg) begin
            new_mode = opsup_pkg::RMODE_C;
        end else if (i_preg) begin
            new_mode = opsup_pkg::RMODE_P;
        end else begin
            new_mode = opsup_pkg::RMODE_NONE;
        end
        s_d.rmode = new_mode;

        // clearing events for latched trips
        s_d.pf_q = i_power_fault;
        s_d.en_q = i_analog_en;
        clr_evt = i_panel_press
                | (s_q.pf_q & ~i_power_fault)
                | (i_analog_en & ~s_q.en_q);

        // register writes in the data phase
        if (s_q.wr_pend) begin
            case (s_q.wr_addr)
                opsup_pkg::ADDR_CTRL: begin
                    s_d.out_req = i_hwdata[opsup_pkg::CTRL_OUT_BIT];
                    s_d.auto_mode = i_hwdata[opsup_pkg::CTRL_AUTO_BIT];
                    s_d.uv_en = i_hwdata[opsup_pkg::CTRL_UVEN_BIT];
                    case (i_hwdata[opsup_pkg::CTRL_FOLD_LSB +: 2])
                        opsup_pkg::FOLD_VOLT: s_d.fold_mode = opsup_pkg::FOLD_VOLT;
                        opsup_pkg::FOLD_CURR: s_d.fold_mode = opsup_pkg::FOLD_CURR;
                        default: s_d.fold_mode = opsup_pkg::FOLD_OFF;
                    endcase
                    if (i_hwdata[opsup_pkg::CTRL_OUT_BIT]) begin
                        clr_evt = 1'b1;
                    end
                end
                opsup_pkg::ADDR_VSET: begin
                    s_d.vset = wv;
                    // keep the floor legal when the setting drops
                    if (s_q.floor > uv_max(wv)) begin
                        s_d.floor = uv_max(wv);
                    end
                end
                opsup_pkg::ADDR_FLOOR: begin
                    if (wv <= uv_max(s_q.vset)) begin
                        s_d.floor = wv;
                    end
                end
                opsup_pkg::ADDR_DELAY: begin
                    // zero is outside 0.1..25.5 s and leaves the delay as it was
                    if (i_hwdata[opsup_pkg::DLY_UV_LSB +: DW] != opsup_pkg::DLY_ZERO) begin
                        s_d.uv_dly = i_hwdata[opsup_pkg::DLY_UV_LSB +: DW];
                    end
                    if (i_hwdata[opsup_pkg::DLY_FOLD_LSB +: DW] != opsup_pkg::DLY_ZERO) begin
                        s_d.fold_dly = i_hwdata[opsup_pkg::DLY_FOLD_LSB +: DW];
                    end
                end
                default: begin
                end
            endcase
        end

        if (clr_evt) begin
            s_d.uv_latch = 1'b0;
            s_d.fold_latch = 1'b0;
        end
        if (i_panel_press & ~(s_q.uv_latch | s_q.fold_latch)) begin
            s_d.out_req = ~s_q.out_req;
        end

        // undervolt timer
        uv_cond = s_q.uv_en & s_q.out_on & (i_vout < s_q.floor);
        if (uv_cond) begin
            if (s_q.tick && s_q.uv_cnt != CNT_MAX) begin
                s_d.uv_cnt = s_q.uv_cnt + CW'(1);
            end
        end else begin
            s_d.uv_cnt = '0;
        end
        uv_trip = uv_cond & (s_q.uv_cnt >= thresh(s_q.uv_dly, s_q.startup));

        // fold detection: a pending transition holds while in the new mode
        case (s_q.fold_mode)
            opsup_pkg::FOLD_VOLT: begin
                fold_evt = (new_mode == opsup_pkg::RMODE_V)
                         & ((s_q.rmode == opsup_pkg::RMODE_C)
                         | (s_q.rmode == opsup_pkg::RMODE_P));
                fold_hold = (new_mode == opsup_pkg::RMODE_V);
            end
            opsup_pkg::FOLD_CURR: begin
                fold_evt = (new_mode == opsup_pkg::RMODE_C)
                         & ((s_q.rmode == opsup_pkg::RMODE_V)
                         | (s_q.rmode == opsup_pkg::RMODE_P));
                fold_hold = (new_mode == opsup_pkg::RMODE_C);
            end
            default: begin
                fold_evt = 1'b0;
                fold_hold = 1'b0;
            end
        endcase
        s_d.fold_pend = s_q.out_on & fold_hold & (s_q.fold_pend | fold_evt);
        if (s_q.fold_pend & s_d.fold_pend) begin
            if (s_q.tick && s_q.fold_cnt != CNT_MAX) begin
                s_d.fold_cnt = s_q.fold_cnt + CW'(1);
            end
        end else begin
            s_d.fold_cnt = '0;
        end
        fold_trip = s_q.fold_pend & s_d.fold_pend
                  & (s_q.fold_cnt >= thresh(s_q.fold_dly, s_q.startup));

        // trips win over a clear in the same cycle
        if (uv_trip) begin
            s_d.uv_latch = 1'b1;
            s_d.out_req = 1'b0;
        end
        if (fold_trip) begin
            s_d.fold_latch = 1'b1;
            s_d.out_req = 1'b0;
        end
        if ((i_overtemp | i_power_fault) & ~s_q.auto_mode) begin
            s_d.out_req = 1'b0;
        end

        s_d.out_on = s_d.out_req & ~s_d.uv_latch & ~s_d.fold_latch
                   & ~i_overtemp & ~i_power_fault & i_analog_en;

        // start-up blanking after each off-to-on transition
        if (s_d.out_on & ~s_q.out_on) begin
            s_d.startup = 1'b1;
            s_d.start_cnt = '0;
        end else if (~s_q.out_on) begin
            s_d.startup = 1'b0;
        end else if (s_q.start_cnt != START_END) begin
            if (s_q.tick) begin
                s_d.start_cnt = s_q.start_cnt + 4'(1);
            end
        end else if (s_q.uv_cnt == '0 && s_q.fold_cnt == '0) begin
            s_d.startup = 1'b0;
        end

        // first-come fault display
        act_uv = s_d.uv_latch;
        act_fold = s_d.fold_latch;
        case (s_q.shown)
            opsup_pkg::FLT_UV:   shown_act = act_uv;
            opsup_pkg::FLT_FOLD: shown_act = act_fold;
            opsup_pkg::FLT_OT:   shown_act = i_overtemp;
            opsup_pkg::FLT_PF:   shown_act = i_power_fault;
            default:             shown_act = 1'b0;
        endcase
        if (!shown_act) begin
            if (i_power_fault) begin
                s_d.shown = opsup_pkg::FLT_PF;
            end else if (i_overtemp) begin
                s_d.shown = opsup_pkg::FLT_OT;
            end else if (act_uv) begin
                s_d.shown = opsup_pkg::FLT_UV;
            end else if (act_fold) begin
                s_d.shown = opsup_pkg::FLT_FOLD;
            end else begin
                s_d.shown = opsup_pkg::FLT_NONE;
            end
        end

        // 1/2 Hz blink: one second on, one second off
        if (s_d.shown == opsup_pkg::FLT_NONE) begin
            s_d.blink = '0;
            s_d.led = 1'b0;
        end else begin
            if (s_q.tick) begin
                s_d.blink = (s_q.blink == BLK_LAST) ? 5'(0) : s_q.blink + 5'(1);
            end
            s_d.led = (s_d.blink < BLK_HALF);
        end

        s_d.off_ind = ~s_d.out_on & (s_d.shown == opsup_pkg::FLT_NONE);
        s_d.fv_ind = (s_d.fold_mode == opsup_pkg::FOLD_VOLT);
        s_d.fi_ind = (s_d.fold_mode == opsup_pkg::FOLD_CURR);

        // address phase: latch write, prepare read word
        s_d.wr_pend = addr_ok & i_hwrite;
        s_d.wr_addr = a8;
        s_d.rdata = '0;
        if (addr_ok & ~i_hwrite & (i_haddr[31:8] == 24'h000000)) begin
            case (a8)
                opsup_pkg::ADDR_CTRL: begin
                    s_d.rdata[opsup_pkg::CTRL_OUT_BIT] = s_q.out_req;
                    s_d.rdata[opsup_pkg::CTRL_AUTO_BIT] = s_q.auto_mode;
                    s_d.rdata[opsup_pkg::CTRL_UVEN_BIT] = s_q.uv_en;
                    s_d.rdata[opsup_pkg::CTRL_FOLD_LSB +: 2] = s_q.fold_mode;
                end
                opsup_pkg::ADDR_VSET:  s_d.rdata[VW-1:0] = s_q.vset;
                opsup_pkg::ADDR_FLOOR: s_d.rdata[VW-1:0] = s_q.floor;
                opsup_pkg::ADDR_DELAY: begin
                    s_d.rdata[opsup_pkg::DLY_UV_LSB +: DW] = s_q.uv_dly;
                    s_d.rdata[opsup_pkg::DLY_FOLD_LSB +: DW] = s_q.fold_dly;
                end
                opsup_pkg::ADDR_STATUS: begin
                    s_d.rdata[opsup_pkg::ST_ON_BIT] = s_q.out_on;
                    s_d.rdata[opsup_pkg::ST_FAULT_LSB +: 3] = s_q.shown;
                    s_d.rdata[opsup_pkg::ST_UVTRIP_BIT] = s_q.uv_latch;
                    s_d.rdata[opsup_pkg::ST_FDL_BIT] = s_q.fold_latch;
                    s_d.rdata[opsup_pkg::ST_OT_BIT] = i_overtemp;
                    s_d.rdata[opsup_pkg::ST_PF_BIT] = i_power_fault;
                    s_d.rdata[opsup_pkg::ST_MODE_LSB +: 2] = s_q.rmode;
                    s_d.rdata[opsup_pkg::ST_START_BIT] = s_q.startup;
                end
                default: s_d.rdata = '0;
            endcase
        end
        if (i_haddr[31:8] != 24'h000000) begin
            s_d.wr_pend = 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            s_q <= '0;
            s_q.vset <= opsup_pkg::VSET_RST;
            s_q.floor <= opsup_pkg::FLOOR_RST;
            s_q.uv_dly <= opsup_pkg::DLY_RST;
            s_q.fold_dly <= opsup_pkg::DLY_RST;
            s_q.fold_mode <= opsup_pkg::FOLD_OFF;
            s_q.shown <= opsup_pkg::FLT_NONE;
            s_q.rmode <= opsup_pkg::RMODE_NONE;
            s_q.off_ind <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_hrdata      = s_q.rdata;
    assign o_hreadyout   = 1'b1;
    assign o_hresp       = 1'b0;
    assign o_out_enable  = s_q.out_on;
    assign o_fault_code  = s_q.shown;
    assign o_alarm_led   = s_q.led;
    assign o_fold_v_ind  = s_q.fv_ind;
    assign o_fold_i_ind  = s_q.fi_ind;
    assign o_out_off_ind = s_q.off_ind;
endmodule : opsup_top
`default_nettype wire

// file: sim/opsup_checker.sv
// port assertions for the supervisor
`default_nettype none
module opsup_checker #(
    parameter int P_TICK_CYCLES = 20  // cycles per tick
) (
    input wire logic       i_mclk,        // clock
    input wire logic       i_rst,         // reset
    input wire logic       i_overtemp,    // hot
    input wire logic       i_power_fault, // input power bad
    input wire logic       o_out_enable,  // stage on
    input wire logic [2:0] o_fault_code,  // shown fault
    input wire logic       o_alarm_led,   // alarm
    input wire logic       o_out_off_ind  // off shown
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MIN_ON = 4 * P_TICK_CYCLES;
    logic [9:0] on_q;
    // held through a trip so the delay is judged from switch-on
    always_ff @(posedge i_mclk) begin
        if (i_rst || (!o_out_enable && o_fault_code == 3'h0)) begin
            on_q <= 10'h000;
        end else if (o_out_enable && on_q != 10'h3FF) begin
            on_q <= on_q + 10'h001;
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    a_hot_off: assert property (i_overtemp |=> !o_out_enable)
        else $error("output on while hot");
    a_power_off: assert property (i_power_fault |=> !o_out_enable)
        else $error("output on without input power");
    a_fault_off: assert property ((o_fault_code != 3'h0) [*3] |-> !o_out_enable)
        else $error("output on with fault shown");
    a_off_shown: assert property (o_out_enable |-> !o_out_off_ind)
        else $error("off shown while on");
    a_alarm_quiet: assert property ((o_fault_code == 3'h0) [*2] |-> !o_alarm_led)
        else $error("alarm without fault");
    a_alarm_start: assert property ($rose(o_fault_code != 3'h0) |-> ##[0:2] o_alarm_led)
        else $error("alarm late");
    a_hot_shown: assert property
        ($rose(i_overtemp) && o_fault_code == 3'h0 |-> ##[1:2] o_fault_code == 3'h2)
        else $error("overtemp not shown");
    a_trip_delay: assert property
        ($rose(o_fault_code == 3'h1 || o_fault_code == 3'h3) |-> on_q >= MIN_ON)
        else $error("trip before delay");
    c_uv: cover property (o_fault_code == 3'h1);
    c_fold: cover property (o_fault_code == 3'h3);
    c_pf: cover property (o_fault_code == 3'h6);
endmodule : opsup_checker
`default_nettype wire

// file: sim/opsup_plant.sv
// behavioural power stage and regulation loop
`default_nettype none
module opsup_plant (
    input  wire logic       i_mclk, // clock
    input  wire logic       i_on,   // stage enable
    input  wire logic       i_sag,  // load pulls output low
    input  wire logic [1:0] i_mode, // loop mode when on
    output logic     [15:0] o_vout, // sensed voltage
    output logic      [2:0] o_reg   // v, c, p flags
);
    timeunit 1ns;
    timeprecision 1ps;
    // a dead stage reads zero and regulates nothing
    always_ff @(posedge i_mclk) begin
        o_vout <= !i_on ? 16'h0000 : (i_sag ? 16'h0100 : 16'h03E8);
        o_reg  <= !i_on ? 3'h0 : {i_mode == 2'h1, i_mode == 2'h3, i_mode == 2'h2};
    end
endmodule : opsup_plant
`default_nettype wire

// file: sim/output_protection_supervisor_tb.sv
// self-checking bench for the supervisor
`default_nettype none
module output_protection_supervisor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst = 1, hsel = 0, hwrite = 0, ot = 0, pf = 0, press = 0;
    logic        aen = 1, sag = 0, rdy, en, led, fv, fi, offi;
    logic [1:0]  htrans = 2'h0, mode = 2'h1;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [15:0] vout;
    logic [2:0]  rg, fc;
    int          num_errors = 0, checks_done = 0, cyc = 0;
    initial forever #2 clk = ~clk;
    opsup_top #(.P_TICK_CYCLES(20)) dut (.i_mclk(clk), .i_rst(rst), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(rdy), .o_hrdata(hrdata), .o_hreadyout(rdy),
        .o_hresp(), .i_vout(vout), .i_vreg(rg[2]), .i_creg(rg[1]), .i_preg(rg[0]),
        .i_overtemp(ot), .i_power_fault(pf), .i_panel_press(press), .i_analog_en(aen),
        .o_out_enable(en), .o_fault_code(fc), .o_alarm_led(led), .o_fold_v_ind(fv),
        .o_fold_i_ind(fi), .o_out_off_ind(offi));
    opsup_plant plant (.i_mclk(clk), .i_on(en), .i_sag(sag), .i_mode(mode),
        .o_vout(vout), .o_reg(rg));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge clk); while (!rdy);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (!rdy);
        rd = hrdata;
    endtask : ahb
    task automatic wait_fc(input logic [2:0] code, input int n);
        repeat (n) if (fc !== code) @(posedge clk);
    endtask : wait_fc
    task automatic t_regs();
        ahb(1'b0, 8'h0C, 32'h0);
        chk("delay", 32'h0A0A, rd);
        ahb(1'b1, 8'h80, 32'hFFFF);
        ahb(1'b0, 8'h80, 32'h0);
        chk("unmapped", 32'h0, rd);
        chk("off ind", 32'h1, {31'h0, offi});
        ahb(1'b1, 8'h04, 32'h03E8);
        ahb(1'b1, 8'h08, 32'h03B7);
        ahb(1'b1, 8'h08, 32'h03B8);
        ahb(1'b0, 8'h08, 32'h0);
        chk("floor", 32'h03B7, rd);
        $display("test regs done");
    endtask : t_regs
    task automatic t_uv();
        ahb(1'b1, 8'h0C, 32'h0202);
        ahb(1'b0, 8'h0C, 32'h0);
        chk("delay set", 32'h0202, rd);
        ahb(1'b1, 8'h00, 32'h1);
        sag <= 1'b1;
        repeat (400) @(posedge clk);
        chk("uv disabled", 32'h1, {31'h0, en});
        ahb(1'b1, 8'h08, 32'h03B0);
        ahb(1'b0, 8'h08, 32'h0);
        chk("floor on", 32'h03B0, rd);
        ahb(1'b1, 8'h00, 32'h5);
        repeat (15) @(posedge clk);
        chk("uv wait", 32'h1, {28'h0, fc, en});
        wait_fc(3'h1, 400);
        sag <= 1'b0;
        repeat (50) @(posedge clk);
        chk("uv latch", 32'h5, {27'h0, fc, en, led});
        press <= 1'b1;
        @(posedge clk);
        press <= 1'b0;
        repeat (5) @(posedge clk);
        chk("uv clear", 32'h0, {28'h0, fc, en});
        ahb(1'b1, 8'h00, 32'h5);
        ahb(1'b0, 8'h10, 32'h0);
        chk("startup", 32'h4001, rd & 32'h4001);
        repeat (5) @(posedge clk);
        chk("comm on", 32'h1, {28'h0, fc, en});
        $display("test uv done");
    endtask : t_uv
    task automatic t_fold();
        logic [1:0] fm [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
        logic [1:0] ex [4] = '{2'h2, 2'h1, 2'h0, 2'h0};
        for (int k = 0; k < 4; k++) begin
            ahb(1'b1, 8'h00, {26'h0, fm[k], 4'h1});
            repeat (2) @(posedge clk);
            chk("fold ind", {30'h0, ex[k]}, {30'h0, fv, fi});
        end
        ahb(1'b1, 8'h00, 32'h31);
        repeat (200) @(posedge clk);
        mode <= 2'h3;
        wait_fc(3'h3, 400);
        mode <= 2'h1;
        repeat (20) @(posedge clk);
        chk("fold trip", 32'h6, {28'h0, fc, en});
        aen <= 1'b0;
        repeat (3) @(posedge clk);
        aen <= 1'b1;
        repeat (5) @(posedge clk);
        chk("analog clear", 32'h0, {29'h0, fc});
        ahb(1'b1, 8'h00, 32'h1);
        $display("test fold done");
    endtask : t_fold
    task automatic t_heat();
        ot <= 1'b1;
        repeat (3) @(posedge clk);
        pf <= 1'b1;
        repeat (3) @(posedge clk);
        chk("hot", 32'h4, {28'h0, fc, en});
        ot <= 1'b0;
        repeat (3) @(posedge clk);
        chk("power", 32'h6, {29'h0, fc});
        pf <= 1'b0;
        repeat (5) @(posedge clk);
        chk("safe", 32'h1, {30'h0, en, offi});
        ahb(1'b1, 8'h00, 32'h3);
        ot <= 1'b1;
        repeat (4) @(posedge clk);
        ot <= 1'b0;
        repeat (6) @(posedge clk);
        chk("auto hot", 32'h1, {31'h0, en});
        pf <= 1'b1;
        repeat (4) @(posedge clk);
        pf <= 1'b0;
        repeat (6) @(posedge clk);
        chk("auto power", 32'h1, {31'h0, en});
        $display("test heat done");
    endtask : t_heat
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test
    // hang guard well above the thousand or so cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            finish_test();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_uv();
        t_fold();
        t_heat();
        finish_test();
    end
endmodule : output_protection_supervisor_tb
bind opsup_top opsup_checker #(.P_TICK_CYCLES(P_TICK_CYCLES)) chk_i (.i_mclk(i_mclk),
    .i_rst(i_rst), .i_overtemp(i_overtemp), .i_power_fault(i_power_fault),
    .o_out_enable(o_out_enable), .o_fault_code(o_fault_code), .o_alarm_led(o_alarm_led),
    .o_out_off_ind(o_out_off_ind));
`default_nettype wire
